/* File: src/beac_pkg.sv */
package beac_pkg;
   // Storage geometry
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DEPTH = 512;
   // Register select codes on the I/O port
   localparam logic [1:0] REG_CONTROL = 2'h0;
   localparam logic [1:0] REG_DATA = 2'h1;
   localparam logic [1:0] REG_ADDR_LOW = 2'h2;
   localparam logic [1:0] REG_ADDR_HIGH = 2'h3;
   // Control register fields
   localparam int unsigned BIT_READ_STROBE = 0;
   localparam int unsigned BIT_WRITE_STROBE = 1;
   localparam int unsigned BIT_MASTER_ENABLE = 2;
   localparam int unsigned BIT_READY_IRQ_EN = 3;
   localparam int unsigned BIT_MODE_LO = 4;
   localparam int unsigned BIT_MODE_HI = 5;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
   localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
   localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   // Erased byte value
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Core stall and master window lengths in clock cycles
   localparam int unsigned READ_STALL_CYC = 4;
   localparam int unsigned WRITE_STALL_CYC = 2;
   localparam int unsigned MASTER_WINDOW_CYC = 4;
   // Programming times
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned T_ERASE_WRITE_US = 3400;
   localparam int unsigned T_SPLIT_US = 1800;
   localparam int unsigned ERASE_WRITE_CYC = T_ERASE_WRITE_US * CLK_MHZ;
   localparam int unsigned SPLIT_CYC = T_SPLIT_US * CLK_MHZ;
   // Oscillator cycles per atomic write
   localparam int unsigned OSC_WRITE_CYC = 26368;
   localparam int unsigned OSC_SPLIT_CYC = OSC_WRITE_CYC * T_SPLIT_US / T_ERASE_WRITE_US;
endpackage : beac_pkg

/* File: src/beac_ctrl.sv */
// Overview of operation
// R01 - 512 separate bytes, linear address from zero, each readable and writable alone
// R02 - A storage read stalls the core for four clock cycles
// R03 - Starting a storage write stalls the core for two clock cycles
// R04 - Address is 9 bits over high and low registers; upper bits read zero
// R05 - Address starts undefined; software loads it before any access
// R06 - Data register gives write byte and holds byte fetched by a read
// R07 - Control bits 7 and 6 always read zero
// R08 - Mode field: 00 erase+write, 01 erase, 10 write, 11 reserved
// R09 - Mode field writes ignored while write strobe is set
// R10 - Reset clears mode field to 00 unless programming is in progress
// R11 - Ready interrupt is a level while enabled, global enable set, strobe clear
// R12 - Write strobe starts programming only within four cycles of master enable
// R13 - Master enable clears itself four cycles after software sets it
// R14 - No programming while flash self-programming is active; software waits
// R15 - Software sequence: wait idle, load, set master enable, then strobe within four
// R16 - Write strobe stays set while programming and clears when time elapses
// R17 - Read strobe fetches addressed byte into data register at once
// R18 - During programming no reads and no address changes
// R19 - Write time counted in calibrated oscillator cycles, 26368 per write
// R20 - Software keeps interrupts off through the timed write sequence
// R21 - Software polls write strobe clear before a read
// R22 - Control layout: mode 5..4, master 2, strobe 1, read 0
// R23 - A write in progress completes across a reset
// R24 - Read strobe self-clears and reads back zero
// R25 - Reserved mode code performs no programming action
module beac_ctrl #(
   parameter int unsigned OSC_WRITE_CYCLES = beac_pkg::OSC_WRITE_CYC,
   parameter int unsigned OSC_SPLIT_CYCLES = beac_pkg::OSC_SPLIT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Core I/O register port
   input wire logic [1:0] io_sel,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic core_stall,
   // System status inputs
   input wire logic global_irq_enable,
   input wire logic self_program_enable,
   input wire logic osc_tick,
   // Interrupt request
   output logic ready_irq
);
   // Storage array with its address and data registers
   logic [7:0] mem [beac_pkg::DEPTH];
   logic [beac_pkg::ADDR_W-1:0] storage_address;
   logic [7:0] storage_data;

   // Control register fields
   logic [1:0] prog_mode_field;
   logic ready_irq_enable;
   logic master_write_enable;
   // Power-up value only: no reset, so a write in flight survives one
   logic write_strobe = 1'b0;

   // Window, stall and programming time counters
   logic [2:0] master_cnt;
   logic [2:0] stall_cnt;
   logic [15:0] osc_cnt;

   // Operation latched at the start so software may reload registers
   logic [1:0] busy_mode;
   logic [beac_pkg::ADDR_W-1:0] busy_addr;
   logic [7:0] busy_data;

   // Oscillator tick synchroniser and edge detect
   logic [1:0] osc_sync;
   logic osc_prev;
   logic osc_edge;

   // Access decode
   logic ctl_wr;
   logic data_wr;
   logic addr_low_wr;
   logic addr_high_wr;
   logic arm_req;
   logic start_ok;
   logic read_go;
   logic prog_done;

   function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] code);
      sel_is = sel == code;
   endfunction : sel_is

   function automatic logic [15:0] prog_len(input logic [1:0] mode);
      if (mode == beac_pkg::MODE_ERASE_WRITE) begin
         prog_len = 16'(OSC_WRITE_CYCLES);
      end else begin
         // Reserved code is timed like the split modes though it changes nothing
         prog_len = 16'(OSC_SPLIT_CYCLES);
      end
   endfunction : prog_len

   function automatic logic [7:0] prog_result(input logic [1:0] mode, input logic [7:0] old_byte,
      input logic [7:0] new_byte);
      case (mode)
         beac_pkg::MODE_ERASE_WRITE: begin
            prog_result = new_byte;
         end
         beac_pkg::MODE_ERASE_ONLY: begin
            prog_result = beac_pkg::ERASED_BYTE;
         end
         // Write only can clear bits but never set them
         beac_pkg::MODE_WRITE_ONLY: begin
            prog_result = old_byte & new_byte;
         end
         default: begin
            prog_result = old_byte; // R25
         end
      endcase
   endfunction : prog_result

   function automatic logic [7:0] control_image(input logic [1:0] mode, input logic irq_en, input logic master,
      input logic busy);
      // Bits 7 and 6 are reserved
      control_image = 8'h00; // R07
      control_image[beac_pkg::BIT_MODE_HI:beac_pkg::BIT_MODE_LO] = mode; // R22
      control_image[beac_pkg::BIT_READY_IRQ_EN] = irq_en;
      control_image[beac_pkg::BIT_MASTER_ENABLE] = master;
      control_image[beac_pkg::BIT_WRITE_STROBE] = busy;
      // Read strobe self-clears, so it always reads zero
      control_image[beac_pkg::BIT_READ_STROBE] = 1'b0; // R24
   endfunction : control_image

   // The busy flag blocks address writes and reads
   assign ctl_wr = io_wr && sel_is(io_sel, beac_pkg::REG_CONTROL);
   assign data_wr = io_wr && sel_is(io_sel, beac_pkg::REG_DATA);
   assign addr_low_wr = io_wr && sel_is(io_sel, beac_pkg::REG_ADDR_LOW) && !write_strobe; // R18
   assign addr_high_wr = io_wr && sel_is(io_sel, beac_pkg::REG_ADDR_HIGH) && !write_strobe; // R18
   // Arming needs the master bit with the strobe clear in one access
   assign arm_req = ctl_wr && io_wdata[beac_pkg::BIT_MASTER_ENABLE]
      && !io_wdata[beac_pkg::BIT_WRITE_STROBE];
   assign start_ok = ctl_wr && io_wdata[beac_pkg::BIT_WRITE_STROBE] && !write_strobe
      && master_write_enable && !self_program_enable; // R12 R14
   assign read_go = ctl_wr && io_wdata[beac_pkg::BIT_READ_STROBE] && !write_strobe; // R17 R18
   assign prog_done = write_strobe && osc_edge && osc_cnt == 16'h1; // R16
   assign osc_edge = osc_sync[1] && !osc_prev;

   // Tick comes from another clock: two flip-flops first. No reset, so edges
   // keep counting through a reset and no false edge follows its release
   always_ff @(posedge core_clk) begin
      osc_sync <= {osc_sync[0], osc_tick};
      osc_prev <= osc_sync[1];
   end

   // Address: no reset, undefined until software writes it
   always_ff @(posedge core_clk) begin
      if (addr_low_wr) begin // R05
         storage_address[7:0] <= io_wdata; // R04
      end
      if (addr_high_wr) begin
         storage_address[8] <= io_wdata[0]; // R04
      end
   end

   // Data register, loaded by software or by a read strobe
   always_ff @(posedge core_clk) begin
      if (read_go) begin
         storage_data <= mem[storage_address]; // R17 R06
      end else if (data_wr) begin
         storage_data <= io_wdata; // R06
      end
   end

   // Storage array, updated once when the programming time runs out
   always_ff @(posedge core_clk) begin
      if (prog_done) begin // R01
         mem[busy_addr] <= prog_result(busy_mode, mem[busy_addr], busy_data); // R08
      end
   end

   // Write strobe; not reset, so a write in progress completes across a reset
   always_ff @(posedge core_clk) begin // R23
      if (start_ok) begin
         write_strobe <= 1'b1; // R12
      end else if (prog_done) begin
         write_strobe <= 1'b0; // R16
      end
   end

   // Snapshot taken at start; later register writes do not disturb it
   always_ff @(posedge core_clk) begin
      if (start_ok) begin
         busy_mode <= prog_mode_field;
         busy_addr <= storage_address;
         busy_data <= storage_data;
      end
   end

   // Programming time counted in synchronised oscillator edges
   always_ff @(posedge core_clk) begin
      if (start_ok) begin
         osc_cnt <= prog_len(prog_mode_field); // R19
      end else if (write_strobe && osc_edge) begin
         osc_cnt <= osc_cnt - 16'h1;
      end
   end

   // Mode field. Reset is taken on the clock edge so it can see the busy flag;
   // it therefore needs the clock running while reset is low
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         if (!write_strobe) begin
            prog_mode_field <= beac_pkg::MODE_RESET; // R10
         end
      end else if (ctl_wr && !write_strobe) begin // R09
         prog_mode_field <= io_wdata[beac_pkg::BIT_MODE_HI:beac_pkg::BIT_MODE_LO];
      end
   end

   // Ready interrupt enable
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ready_irq_enable <= 1'b0;
      end else if (ctl_wr) begin
         ready_irq_enable <= io_wdata[beac_pkg::BIT_READY_IRQ_EN];
      end
   end

   // Master enable; writing it together with the strobe does not arm it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         master_write_enable <= 1'b0;
      end else if (arm_req) begin
         master_write_enable <= 1'b1;
      end else if (start_ok) begin
         master_write_enable <= 1'b0;
      end else if (master_cnt == 3'h1) begin
         master_write_enable <= 1'b0; // R13
      end
   end

   // Window counter; the strobe is accepted while it runs
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         master_cnt <= 3'h0;
      end else if (arm_req) begin
         master_cnt <= 3'(beac_pkg::MASTER_WINDOW_CYC); // R12
      end else if (start_ok) begin
         master_cnt <= 3'h0;
      end else if (master_cnt != 3'h0) begin
         master_cnt <= master_cnt - 3'h1;
      end
   end

   // Core stall; advisory, the core must honour it itself
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stall_cnt <= 3'h0;
         core_stall <= 1'b0;
      end else if (read_go) begin
         stall_cnt <= 3'(beac_pkg::READ_STALL_CYC - 1); // R02
         core_stall <= 1'b1;
      end else if (start_ok) begin
         stall_cnt <= 3'(beac_pkg::WRITE_STALL_CYC - 1); // R03
         core_stall <= 1'b1;
      end else if (stall_cnt != 3'h0) begin
         stall_cnt <= stall_cnt - 3'h1;
      end else begin
         core_stall <= 1'b0;
      end
   end

   // Interrupt level, registered
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ready_irq <= 1'b0;
      end else begin
         ready_irq <= ready_irq_enable && global_irq_enable && !write_strobe; // R11
      end
   end

   // Read data holds until the next read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         case (io_sel)
            beac_pkg::REG_CONTROL: begin
               io_rdata <= control_image(prog_mode_field, ready_irq_enable, master_write_enable, write_strobe);
            end
            beac_pkg::REG_DATA: begin
               io_rdata <= storage_data;
            end
            beac_pkg::REG_ADDR_LOW: begin
               io_rdata <= storage_address[7:0];
            end
            beac_pkg::REG_ADDR_HIGH: begin
               io_rdata <= {7'h00, storage_address[8]}; // R04
            end
            default: begin
               io_rdata <= 8'h00;
            end
         endcase
      end
   end
endmodule : beac_ctrl

/* File: tb/beac_ctrl_properties.sv */
module beac_ctrl_properties #(
   parameter int unsigned OSC_WRITE_CYCLES = 8,
   parameter int unsigned OSC_SPLIT_CYCLES = 4
) (
   // Watched ports
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [1:0] io_sel,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic core_stall,
   input wire logic global_irq_enable,
   input wire logic self_program_enable,
   input wire logic osc_tick,
   input wire logic ready_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [2:0] age;
   wire logic cw = io_wr && io_sel == beac_pkg::REG_CONTROL;
   wire logic rc = io_rd && io_sel == beac_pkg::REG_CONTROL;
   wire logic go = cw && io_wdata[1] && !io_wdata[2] && age < 3'h4 && !self_program_enable;
   // Saturates so a stale arm never counts
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn) age <= 3'h7;
      else if (cw && io_wdata[2] && !io_wdata[1]) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
   a_read_stall: assert property (cw && io_wdata[0] |=> core_stall [*4] ##1 !core_stall)
      else $error("read stall length wrong");
   a_write_stall: assert property (go |=> core_stall [*2] ##1 !core_stall)
      else $error("write stall length wrong");
   a_stall_cause: assert property ($rose(core_stall) |-> $past(cw))
      else $error("stall without access");
   a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata))
      else $error("read data moved");
   a_addr_high_zero: assert property (io_rd && io_sel == beac_pkg::REG_ADDR_HIGH |=> io_rdata[7:1] == 7'h00)
      else $error("address high bits set");
   a_ctl_reserved: assert property (rc |=> io_rdata[7:6] == 2'h0)
      else $error("control top bits set");
   a_read_clears: assert property (rc |=> !io_rdata[0])
      else $error("read strobe stuck");
   a_irq_global: assert property (ready_irq |-> $past(global_irq_enable))
      else $error("irq without global enable");
   a_irq_drop: assert property (go |-> ##2 !ready_irq)
      else $error("irq while writing");
endmodule : beac_ctrl_properties

/* File: tb/beac_core_model.sv */
module beac_core_model (
   // Clock and stall
   input wire logic core_clk,
   input wire logic core_stall,
   // I/O register port
   output logic [1:0] io_sel,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // Oscillator, free running, unrelated in phase
   output logic osc_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {io_sel, io_wr, io_rd, io_wdata, osc_tick} = 13'h0000;
   always #37 osc_tick = ~osc_tick;
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      int n;
      @(negedge core_clk);
      {io_sel, io_wdata, io_wr} = {s, d, 1'b1};
      @(negedge core_clk);
      {io_wdata, io_wr} = {~d, 1'b0};
      // The core sits still while stalled
      for (n = 0; core_stall === 1'b1 && n < 8; n++) @(negedge core_clk);
   endtask : wr
   task automatic rd(input logic [1:0] s, output logic [7:0] v);
      @(negedge core_clk);
      {io_sel, io_rd} = {s, 1'b1};
      @(negedge core_clk);
      io_rd = 1'b0;
      v = io_rdata;
   endtask : rd
endmodule : beac_core_model

/* File: tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic gie = 1'b0;
   logic spe = 1'b0;
   logic rd_d = 1'b0;
   wire logic [1:0] sel;
   wire logic wr, rd, osc, stall, irq;
   wire logic [7:0] wd, rdat;
   int n_errors = 0;
   int cmp_count = 0;
   logic [15:0] expq[$];
   logic [8:0] a;
   logic [7:0] d, e;
   always #2.5 core_clk = ~core_clk;
   beac_core_model u_core (.core_clk(core_clk), .core_stall(stall), .io_sel(sel), .io_wr(wr), .io_rd(rd),
      .io_wdata(wd), .io_rdata(rdat), .osc_tick(osc));
   beac_ctrl #(.OSC_WRITE_CYCLES(8), .OSC_SPLIT_CYCLES(4)) u_dut (.core_clk(core_clk), .resetn(resetn),
      .io_sel(sel), .io_wr(wr), .io_rd(rd), .io_wdata(wd), .io_rdata(rdat), .core_stall(stall),
      .global_irq_enable(gie), .self_program_enable(spe), .osc_tick(osc), .ready_irq(irq));
   task automatic cmp_rdata(input logic [15:0] note);
      cmp_count++;
      if ((rdat & note[15:8]) !== note[7:0]) begin
         n_errors++;
         $display("mismatch io_rdata expected %h seen %h", note[7:0], rdat & note[15:8]);
      end
   endtask : cmp_rdata
   always @(posedge core_clk) begin
      if (rd_d && expq.size() != 0) cmp_rdata(expq.pop_front());
      rd_d <= rd;
   end
   task automatic chk(input logic [1:0] s, input logic [7:0] x, input logic [7:0] m);
      logic [7:0] v;
      expq.push_back({m, x & m});
      u_core.rd(s, v);
   endtask : chk
   task automatic poll;
      logic [7:0] v;
      int n;
      for (n = 0; n == 0 || (v[1] !== 1'b0 && n < 400); n++) begin
         expq.push_back(16'h0000);
         u_core.rd(2'h0, v);
      end
   endtask : poll
   task automatic at_addr(input logic [7:0] lo);
      u_core.wr(2'h2, lo);
      u_core.wr(2'h3, {7'h00, a[8]});
   endtask : at_addr
   task automatic prog(input logic [1:0] m, input logic [7:0] x, input bit w);
      at_addr(a[7:0]);
      u_core.wr(2'h1, x);
      u_core.wr(2'h0, {2'h0, m, 4'hc});
      u_core.wr(2'h0, {2'h0, m, 4'ha});
      if (w) begin
         u_core.wr(2'h0, {2'h0, ~m, 4'h8});
         at_addr(~a[7:0]);
         poll();
         chk(2'h0, {2'h0, m, 4'h8}, 8'hff);
         chk(2'h2, a[7:0], 8'hff);
      end
   endtask : prog
   task automatic rd_byte(input logic [7:0] x);
      at_addr(a[7:0]);
      u_core.wr(2'h0, 8'h09);
      chk(2'h1, x, 8'hff);
   endtask : rd_byte
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   initial begin
      void'($urandom(23263));
      repeat (3) @(negedge core_clk);
      resetn = 1'b1;
      chk(2'h0, 8'h00, 8'hff);
      chk(2'h3, 8'h00, 8'hfe);
      a = 9'($urandom);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         gie = 1'($urandom);
         prog(2'(i), d, 1'b1);
         e = i == 0 ? d : i == 1 ? 8'hff : i == 2 ? e & d : e;
         rd_byte(e);
         $display("test mode %0d done", i);
      end
      u_core.wr(2'h0, 8'h02);
      chk(2'h0, 8'h00, 8'h02);
      u_core.wr(2'h0, 8'h04);
      repeat (4) @(negedge core_clk);
      chk(2'h0, 8'h00, 8'h04);
      u_core.wr(2'h0, 8'h02);
      spe = 1'b1;
      prog(2'h0, ~e, 1'b0);
      chk(2'h0, 8'h00, 8'h02);
      spe = 1'b0;
      rd_byte(e);
      $display("test refused strobes done");
      prog(2'h1, 8'h00, 1'b0);
      resetn = 1'b0;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      chk(2'h0, 8'h12, 8'h32);
      poll();
      rd_byte(8'hff);
      $display("test reset in write done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      close_out();
   end
endmodule : testbench
bind beac_ctrl beac_ctrl_properties #(.OSC_WRITE_CYCLES(OSC_WRITE_CYCLES), .OSC_SPLIT_CYCLES(OSC_SPLIT_CYCLES))
   u_props (.core_clk(core_clk), .resetn(resetn), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .core_stall(core_stall), .global_irq_enable(global_irq_enable),
   .self_program_enable(self_program_enable), .osc_tick(osc_tick), .ready_irq(ready_irq));
